/* File: pkg/sysref_out_defines.vh */
// constants for the sysref output state control block
`ifndef SYSREF_OUT_DEFINES_VH
`define SYSREF_OUT_DEFINES_VH
// number of sysref outputs
`define NUM_OUTS 4
// output format codes {format_hi_sel, format_sel}
`define FMT_LVDS 2'b00
`define FMT_LVPECL 2'b01
`define FMT_RSVD 2'b10
`define FMT_HCSL 2'b11
// amplitude codes
`define AMP_350 2'b00
`define AMP_750 2'b01
`define AMP_1000A 2'b10
`define AMP_1000B 2'b11
// amplitude level codes presented to the driver
`define LVL_350 2'b00
`define LVL_750 2'b01
`define LVL_1000 2'b10
`define LVL_NONE 2'b11
// reset values
`define RST_AMP 2'b01
`define RST_BIT 1'b0
// leg drive states: low, high, crosspoint, toggling
`define LEG_LOW 2'b00
`define LEG_HIGH 2'b01
`define LEG_XPT 2'b10
`define LEG_SWITCH 2'b11
// per-output state codes
`define ST_IDLE 2'b00
`define ST_RUN 2'b01
`define ST_OFF 2'b10
`endif

/* File: logic/sysref_out_lane.v */
// one sysref output lane: configuration registers and drive state
`timescale 1ns/1ns
`include "sysref_out_defines.vh"
module sysref_out_lane (
  input wire sys_clk,
  input wire srst,
  input wire cfgWrite,
  input wire cfgBiasSel,
  input wire [1:0] cfgAmp,
  input wire cfgPowerdown,
  input wire cfgFormatHi,
  input wire cfgFormat,
  input wire cfgGate,
  input wire biasKind,
  input wire globalPd,
  input wire rearm,
  input wire refRise,
  output reg outBiasSel,
  output reg [1:0] ampSel,
  output reg outPowerdown,
  output reg formatHiSel,
  output reg formatSel,
  output reg outGate,
  output reg [1:0] trueLeg,
  output reg [1:0] compLeg,
  output reg [1:0] ampLevel,
  output reg ampReserved,
  output reg fmtReserved,
  output reg driverOn
);
  // ----------------------------------------
  // lane state
  // ----------------------------------------
  reg [1:0] state;
  reg [1:0] next_state;
  reg [1:0] next_true;
  reg [1:0] next_comp;
  reg [1:0] next_level;
  wire [1:0] fmt = {formatHiSel, formatSel};
  wire isLvds = (fmt == `FMT_LVDS);
  wire active = ~outPowerdown & outGate & ~globalPd;

  // own copy of every per-output field
  always @(posedge sys_clk) begin
    if (srst) begin
      outBiasSel <= `RST_BIT; // [R05]
      ampSel <= `RST_AMP; // [R06]
      outPowerdown <= `RST_BIT; // [R07]
      formatHiSel <= `RST_BIT; // [R08]
      formatSel <= `RST_BIT; // [R08]
      outGate <= `RST_BIT; // [R09]
    end else if (cfgWrite) begin // [R13]
      outBiasSel <= cfgBiasSel;
      ampSel <= cfgAmp;
      outPowerdown <= cfgPowerdown;
      formatHiSel <= cfgFormatHi;
      formatSel <= cfgFormat;
      outGate <= cfgGate;
    end
  end

  // idle waits for the first reference edge; run keeps switching
  always @* begin
    next_state = state;
    case (state)
      `ST_IDLE: begin
        if (!active) begin
          next_state = `ST_OFF;
        end else if (refRise && !(isLvds && outBiasSel)) begin // [R01] [R03]
          next_state = `ST_RUN;
        end
      end
      `ST_RUN: begin
        if (!active) begin
          next_state = `ST_OFF;
        end else if (isLvds && outBiasSel) begin
          // blocking an lvds lane mid-run drops it back to a static idle
          next_state = `ST_IDLE; // [R02] [R04]
        end
      end
      `ST_OFF: begin
        // leaving power-down goes back to idle, never straight to switching
        if (active) begin
          next_state = `ST_IDLE;
        end
      end
      default: next_state = `ST_OFF;
    endcase
    if (rearm && active) begin
      next_state = `ST_IDLE; // [R14]
    end
  end

  // leg drive decode
  always @* begin
    next_true = `LEG_LOW;
    next_comp = `LEG_HIGH;
    if (outPowerdown || !outGate || globalPd || next_state == `ST_OFF) begin
      next_true = `LEG_LOW; // [R07] [R09] [R12]
      next_comp = `LEG_HIGH;
    end else if (next_state == `ST_RUN && !(isLvds && outBiasSel)) begin // [R02] [R04]
      next_true = `LEG_SWITCH;
      next_comp = `LEG_SWITCH;
    end else if (isLvds && biasKind) begin
      next_true = `LEG_XPT; // [R03] [R04]
      next_comp = `LEG_XPT;
    end else begin
      next_true = `LEG_LOW; // [R01] [R02] [R05]
      next_comp = `LEG_HIGH;
    end
  end

  // amplitude decode; lvds upper codes are flagged, not driven
  always @* begin
    case (ampSel)
      `AMP_350: next_level = `LVL_350;
      `AMP_750: next_level = `LVL_750;
      `AMP_1000A: next_level = isLvds ? `LVL_NONE : `LVL_1000; // [R06]
      `AMP_1000B: next_level = isLvds ? `LVL_NONE : `LVL_1000; // [R06]
      default: next_level = `LVL_NONE;
    endcase
    if (outPowerdown) begin
      next_level = `LVL_NONE; // [R07]
    end
  end

  // registered outputs
  always @(posedge sys_clk) begin
    if (srst) begin
      state <= `ST_OFF;
      trueLeg <= `LEG_LOW;
      compLeg <= `LEG_HIGH;
      ampLevel <= `LVL_NONE;
      ampReserved <= 1'b0;
      fmtReserved <= 1'b0;
      driverOn <= 1'b0;
    end else begin
      state <= next_state;
      trueLeg <= next_true;
      compLeg <= next_comp;
      ampLevel <= next_level;
      ampReserved <= isLvds & ampSel[1] & ~outPowerdown; // [R06]
      fmtReserved <= (fmt == `FMT_RSVD) & ~outPowerdown; // [R08]
      driverOn <= ~outPowerdown & ~globalPd; // [R07] [R12]
    end
  end
endmodule

/* File: logic/sysref_output_state_control.v */
// top of the sysref output state control: shared bias, global power-down, four lanes
`timescale 1ns/1ns
`include "sysref_out_defines.vh"
// Function
// [R01] dc bias with bias select clear idles lvds low/high and switches from the first reference rising edge.
// [R02] dc bias with bias select set holds lvds static low/high through sysref events.
// [R03] ac bias with bias select clear idles both legs at the crosspoint and switches from the first rising edge.
// [R04] ac bias with bias select set holds both legs at the crosspoint through sysref events.
// [R05] the bias select has no effect on lvpecl outputs and resets to zero.
// [R06] amplitude resets to 01, lvpecl maps codes to 350/750/1000/1000 mV, lvds upper codes are reserved.
// [R07] per-output power-down overrides format, gate and amplitude and resets to powered up.
// [R08] format pair decodes 00 lvds, 01 lvpecl, 11 ac-hcsl, 10 reserved, both reset to zero.
// [R09] gate clear holds the output disabled low, gate set enables it, reset clear.
// [R10] software pulses global power-down after setting ac bias to move legs to the crosspoint.
// [R11] software repeats the global power-down pulse after sysref generation stops.
// [R12] global power-down set powers down all sysref blocks, clear powers them up, resets to zero.
// [R13] each output owns its field copies and all outputs share the bias kind.
// [R14] the falling edge of global power-down re-arms lvds outputs to the idle state.
module sysref_output_state_control #(
  parameter NOUT = `NUM_OUTS
) (
  input wire sys_clk,
  input wire srst,
  input wire sysrefIn,
  input wire biasKindWrite,
  input wire biasKindIn,
  input wire globalPdWrite,
  input wire globalPdIn,
  input wire [NOUT-1:0] laneWrite,
  input wire [NOUT-1:0] cfgBiasSel,
  input wire [2*NOUT-1:0] cfgAmp,
  input wire [NOUT-1:0] cfgPowerdown,
  input wire [NOUT-1:0] cfgFormatHi,
  input wire [NOUT-1:0] cfgFormat,
  input wire [NOUT-1:0] cfgGate,
  output reg biasKind,
  output reg sysrefGlobalPd,
  output wire [NOUT-1:0] outBiasSel,
  output wire [2*NOUT-1:0] ampSel,
  output wire [NOUT-1:0] outPowerdown,
  output wire [NOUT-1:0] formatHiSel,
  output wire [NOUT-1:0] formatSel,
  output wire [NOUT-1:0] outGate,
  output wire [2*NOUT-1:0] sysrefOutTrue,
  output wire [2*NOUT-1:0] sysrefOutComplement,
  output wire [2*NOUT-1:0] ampLevel,
  output wire [NOUT-1:0] ampReserved,
  output wire [NOUT-1:0] fmtReserved,
  output wire [NOUT-1:0] driverOn,
  output reg sysrefActive
);
  // ----------------------------------------
  // reference input synchroniser
  // ----------------------------------------
  reg refMeta;
  reg refSyncA;
  reg refSyncB;
  reg refLevel;
  reg refRise;
  reg rearm;

  // a change counts once the second and third stages agree
  always @(posedge sys_clk) begin
    if (srst) begin
      refMeta <= 1'b0;
      refSyncA <= 1'b0;
      refSyncB <= 1'b0;
      refLevel <= 1'b0;
      refRise <= 1'b0;
    end else begin
      refMeta <= sysrefIn;
      refSyncA <= refMeta;
      refSyncB <= refSyncA;
      if (refSyncA == refSyncB) begin
        refLevel <= refSyncB;
      end
      refRise <= (refSyncA == refSyncB) & refSyncB & ~refLevel;
    end
  end

  // ----------------------------------------
  // shared controls
  // ----------------------------------------
  // global power-down falling edge produces the crosspoint re-arm pulse
  always @(posedge sys_clk) begin
    if (srst) begin
      biasKind <= `RST_BIT;
      sysrefGlobalPd <= `RST_BIT; // [R12]
      rearm <= 1'b0;
      sysrefActive <= 1'b0;
    end else begin
      if (biasKindWrite) begin
        biasKind <= biasKindIn; // [R13]
      end
      if (globalPdWrite) begin
        sysrefGlobalPd <= globalPdIn; // [R12]
      end
      // one-cycle pulse; relies on software pulsing per [R10] [R11]
      rearm <= globalPdWrite & sysrefGlobalPd & ~globalPdIn; // [R14]
      sysrefActive <= ~sysrefGlobalPd & refLevel;
    end
  end

  // ----------------------------------------
  // output lanes
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < NOUT; i = i + 1) begin : lane
      sysref_out_lane u_lane (
        .sys_clk(sys_clk),
        .srst(srst),
        .cfgWrite(laneWrite[i]),
        .cfgBiasSel(cfgBiasSel[i]),
        .cfgAmp(cfgAmp[2*i+1:2*i]),
        .cfgPowerdown(cfgPowerdown[i]),
        .cfgFormatHi(cfgFormatHi[i]),
        .cfgFormat(cfgFormat[i]),
        .cfgGate(cfgGate[i]),
        .biasKind(biasKind),
        .globalPd(sysrefGlobalPd),
        .rearm(rearm),
        .refRise(refRise),
        .outBiasSel(outBiasSel[i]),
        .ampSel(ampSel[2*i+1:2*i]),
        .outPowerdown(outPowerdown[i]),
        .formatHiSel(formatHiSel[i]),
        .formatSel(formatSel[i]),
        .outGate(outGate[i]),
        .trueLeg(sysrefOutTrue[2*i+1:2*i]),
        .compLeg(sysrefOutComplement[2*i+1:2*i]),
        .ampLevel(ampLevel[2*i+1:2*i]),
        .ampReserved(ampReserved[i]),
        .fmtReserved(fmtReserved[i]),
        .driverOn(driverOn[i])
      );
    end
  endgenerate
endmodule

/* File: tb/sysref_output_state_control_checker.sv */
// port-level assertions for the sysref output state control
`timescale 1ns/1ns
module sysref_output_state_control_checker #(
  parameter NOUT = 4
) (
  input wire sys_clk,
  input wire srst,
  input wire sysrefIn,
  input wire biasKind,
  input wire sysrefGlobalPd,
  input wire [NOUT-1:0] outBiasSel,
  input wire [2*NOUT-1:0] ampSel,
  input wire [NOUT-1:0] outPowerdown,
  input wire [NOUT-1:0] formatHiSel,
  input wire [NOUT-1:0] formatSel,
  input wire [NOUT-1:0] outGate,
  input wire [2*NOUT-1:0] sysrefOutTrue,
  input wire [2*NOUT-1:0] sysrefOutComplement,
  input wire [2*NOUT-1:0] ampLevel,
  input wire [NOUT-1:0] ampReserved,
  input wire [NOUT-1:0] fmtReserved,
  input wire [NOUT-1:0] driverOn
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // lane 0 only, except a_gpd which checks all lanes: every lane is the same logic
  wire lvds0 = !formatHiSel[0] && !formatSel[0];
  wire en0 = lvds0 && outGate[0] && !outPowerdown[0] && !sysrefGlobalPd;
  wire [1:0] t0 = sysrefOutTrue[1:0];
  wire [1:0] c0 = sysrefOutComplement[1:0];
  property p_gpd; sysrefGlobalPd |=> driverOn == '0 && sysrefOutTrue == '0; endproperty
  a_gpd: assert property (p_gpd) else $error("global pd leaves drivers on");
  property p_pd; outPowerdown[0] |=> ampLevel[1:0] == 2'b11 && !driverOn[0]; endproperty
  a_pd: assert property (p_pd) else $error("powered-down lane still active");
  property p_gate; !outGate[0] |=> t0 == 2'b00 && c0 == 2'b01; endproperty
  a_gate: assert property (p_gate) else $error("gated lane not low");
  property p_pecl;
    formatSel[0] && !formatHiSel[0] && !outPowerdown[0]
      |=> ampLevel[1:0] == ($past(ampSel[1]) ? 2'b10 : $past(ampSel[1:0]));
  endproperty
  a_pecl: assert property (p_pecl) else $error("lvpecl amplitude wrong");
  property p_fmt;
    1 |=> fmtReserved[0] == $past(formatHiSel[0] && !formatSel[0] && !outPowerdown[0]);
  endproperty
  a_fmt: assert property (p_fmt) else $error("reserved format flag wrong");
  property p_ampr; 1 |=> ampReserved[0] == $past(lvds0 && ampSel[1] && !outPowerdown[0]); endproperty
  a_ampr: assert property (p_ampr) else $error("reserved amplitude flag wrong");
  // three cycles of settled config so the one-stage leg latency has passed
  property p_dcblk; (en0 && outBiasSel[0] && !biasKind) [*3] |=> t0 == 2'b00 && c0 == 2'b01; endproperty
  a_dcblk: assert property (p_dcblk) else $error("dc blocked lane moved");
  property p_acblk; (en0 && outBiasSel[0] && biasKind) [*3] |=> t0 == 2'b10 && c0 == 2'b10; endproperty
  a_acblk: assert property (p_acblk) else $error("ac blocked lane off crosspoint");
  property p_sw; $rose(sysrefIn) && en0 && !outBiasSel[0] && !biasKind |-> ##[4:7] (t0 == 2'b11 || !en0); endproperty
  a_sw: assert property (p_sw) else $error("lane did not start switching");
  c_sw: cover property (t0 == 2'b11);
  c_xpt: cover property (t0 == 2'b10);
  c_rearm: cover property ($fell(sysrefGlobalPd));
endmodule
bind sysref_output_state_control sysref_output_state_control_checker #(.NOUT(NOUT)) chk (.*);

/* File: tb/sysref_rx_model.sv */
// converter-side receiver: counts cycles in which one lane switches
`timescale 1ns/1ns
module sysref_rx_model (
  input wire sys_clk,
  input wire srst,
  input wire [1:0] legT,
  input wire [1:0] legC,
  output reg [7:0] pulses
);
  // static levels, even crosspoint, never register as a capture
  always @(posedge sys_clk) begin
    if (srst) pulses <= 8'h00;
    else if (legT == 2'b11 && legC == 2'b11) pulses <= pulses + 8'h01;
  end
endmodule

/* File: tb/sysref_output_state_control_tb.sv */
// self-checking bench for the sysref output state control
`timescale 1ns/1ns
module sysref_output_state_control_tb;
  reg sys_clk = 1'b0, srst = 1'b1, sysrefIn = 1'b0;
  reg biasKindWrite = 1'b0, biasKindIn = 1'b0, globalPdWrite = 1'b0, globalPdIn = 1'b0;
  reg [3:0] laneWrite = 4'h0, cfgBiasSel = 4'h0, cfgPowerdown = 4'h0;
  reg [3:0] cfgFormatHi = 4'h0, cfgFormat = 4'h0, cfgGate = 4'h0;
  reg [7:0] cfgAmp = 8'h00, p;
  wire biasKind, sysrefGlobalPd, sysrefActive;
  wire [3:0] outBiasSel, outPowerdown, formatHiSel, formatSel, outGate, ampReserved, fmtReserved, driverOn;
  wire [7:0] ampSel, sysrefOutTrue, sysrefOutComplement, ampLevel, pulses0;
  integer n_fail = 0, total_checks = 0, cyc = 0, i;
  always #25 sys_clk = ~sys_clk;
  sysref_output_state_control #(.NOUT(4)) uut (.*);
  sysref_rx_model rx0 (.sys_clk(sys_clk), .srst(srst), .legT(sysrefOutTrue[1:0]),
    .legC(sysrefOutComplement[1:0]), .pulses(pulses0));
  task end_sim;
    begin
      $display("checks %0d errors %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // a hang costs a mismatch; the run needs well under 1000 cycles
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // whole-lane write to lanes m; f = {bias, amp[1:0], pd, fmtHi, fmt, gate}
  task wrl(input [3:0] m, input [6:0] f);
    begin
      cfgBiasSel = {4{f[6]}};
      cfgAmp = {4{f[5:4]}};
      cfgPowerdown = {4{f[3]}};
      cfgFormatHi = {4{f[2]}};
      cfgFormat = {4{f[1]}};
      cfgGate = {4{f[0]}};
      laneWrite = m;
      @(negedge sys_clk);
      laneWrite = 4'h0;
      repeat (3) @(negedge sys_clk);
    end
  endtask
  // k selects the bias kind write, otherwise global power-down
  task wrg(input k, input v);
    begin
      biasKindIn = v;
      globalPdIn = v;
      biasKindWrite = k;
      globalPdWrite = ~k;
      @(negedge sys_clk);
      biasKindWrite = 1'b0;
      globalPdWrite = 1'b0;
      repeat (3) @(negedge sys_clk);
    end
  endtask
  // reference held long enough to pass the synchroniser and filter
  task refp(input [7:0] et);
    begin
      sysrefIn = 1'b1;
      repeat (8) @(negedge sys_clk);
      chk("legs", et, sysrefOutTrue);
      chk("active", 8'h01, {7'h00, sysrefActive});
      sysrefIn = 1'b0;
      repeat (8) @(negedge sys_clk);
    end
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    chk("ampSel", 8'h55, ampSel);
    chk("biasGate", 8'h00, {outBiasSel, outGate});
    chk("format", 8'h00, {formatHiSel, formatSel});
    chk("globals", 8'h00, {6'h00, biasKind, sysrefGlobalPd});
    chk("compl", 8'h55, sysrefOutComplement);
    wrl(4'hf, 7'h11);
    chk("idle", 8'h00, sysrefOutTrue);
    refp(8'hff);
    chk("rxSeen", 8'h00, {7'h00, pulses0 == 8'h00});
    wrl(4'h1, 7'h51);
    p = pulses0;
    refp(8'hfc);
    chk("rxStill", p, pulses0);
    for (i = 0; i < 4; i = i + 1) begin
      wrl(4'h1, {1'b1, i[1:0], 4'h3});
      chk("peclLvl", (i > 1) ? 8'h02 : i[7:0], {6'h00, ampLevel[1:0]});
    end
    refp(8'hff);
    wrl(4'h1, 7'h21);
    chk("ampRsv", 8'h13, {ampReserved, 2'b00, ampLevel[1:0]});
    wrl(4'h1, 7'h15);
    chk("fmtRsv", 8'h01, {4'h0, fmtReserved});
    wrl(4'h1, 7'h19);
    chk("pd", 8'he3, {driverOn, 2'b00, ampLevel[1:0]});
    wrl(4'h1, 7'h10);
    chk("gate", 8'h04, {4'h0, sysrefOutComplement[1:0], sysrefOutTrue[1:0]});
    wrl(4'hf, 7'h11);
    wrg(1'b1, 1'b1);
    wrg(1'b0, 1'b1);
    chk("gpd", 8'h00, {driverOn, sysrefOutTrue[3:0]});
    wrg(1'b0, 1'b0);
    chk("xpt", 8'haa, sysrefOutTrue & sysrefOutComplement);
    wrl(4'h1, 7'h51);
    chk("xptHold", 8'haa, sysrefOutTrue);
    refp(8'hfe);
    wrg(1'b0, 1'b1);
    wrg(1'b0, 1'b0);
    chk("rearm", 8'haa, sysrefOutTrue);
    end_sim;
  end
endmodule
